// File: src/ipbm_top.sv
// Peripheral port and memory data port monitor with AXI4-Lite registers
`timescale 1ns/1ps
`default_nettype none
`include "ipbm_map.svh"
// Notes on behaviour
// - Invalid accesses raise a bus error only inside the three covered address ranges
// - Error enable bit 15 resets to one; cleared, covered invalid access hangs the port
// - Covered invalid access sets access error flag bit 15
// - Failing covered write sets write error flag bit 4
// - Failing covered read sets read error flag bit 3
// - Data returned with a bus error is undefined; requester discards it
// - No peripheral response within 512 cycles sets time-out flag bit 12
// - Peripheral time-out works only while its enable bit is set
// - Idle request plus idle instruction idles the port; no requests, no checks
// - Idling the peripheral port with neither domain idle raises a bus error
// - Two posting entries; with posting enabled and the port awake, writer stalls only when both are full
// - Posting only with posting enable set; otherwise one entry holds a single write
// - Enabled external memory time-out sets flag bit 12
// - Idle data port takes no memory requests
// - Idling the data port with neither domain idle raises a bus error
module ipbm_top #(
	parameter int PP_TO_CYC = `IPBM_PP_TO_CYC,
	parameter int EM_TO_CYC = `IPBM_EM_TO_CYC,
	parameter int AW        = 24,
	parameter int DW        = 32
) (
	input  wire logic          aclk,
	input  wire logic          aresetn,
	input  wire logic          awvalid,
	output logic               awready,
	input  wire logic [31:0]   awaddr,
	input  wire logic          wvalid,
	output logic               wready,
	input  wire logic [31:0]   wdata,
	input  wire logic [3:0]    wstrb,
	output logic               bvalid,
	input  wire logic          bready,
	output logic [1:0]         bresp,
	input  wire logic          arvalid,
	output logic               arready,
	input  wire logic [31:0]   araddr,
	output logic               rvalid,
	input  wire logic          rready,
	output logic [31:0]        rdata,
	output logic [1:0]         rresp,
	input  wire logic          pp_req_valid,
	output logic               pp_req_ready,
	input  wire logic [15:0]   pp_req_addr,
	input  wire logic          pp_req_write,
	input  wire logic          pp_req_invalid,
	input  wire logic          pp_resp,
	output logic               pp_done,
	output logic               pp_err,
	input  wire logic          idle_insn,
	input  wire logic          cpu_idle,
	input  wire logic          master_idle,
	input  wire logic          wake,
	output logic               pp_idle,
	output logic               dp_idle,
	output logic               idle_bus_err,
	input  wire logic          dp_wr_valid,
	output logic               dp_wr_ready,
	input  wire logic [AW-1:0] dp_wr_addr,
	input  wire logic [DW-1:0] dp_wr_data,
	output logic               em_wr_valid,
	input  wire logic          em_wr_ready,
	output logic [AW-1:0]      em_wr_addr,
	output logic [DW-1:0]      em_wr_data,
	output logic               irq
);
	localparam int PTW = $clog2(PP_TO_CYC);
	localparam int ETW = $clog2(EM_TO_CYC);
	localparam logic [PTW-1:0] PP_LAST = PTW'(PP_TO_CYC - 1);
	localparam logic [ETW-1:0] EM_LAST = ETW'(EM_TO_CYC - 1);

	typedef struct packed {
		ipbm_pkg::ipbm_pp_state_type pp_st;
		logic [PTW-1:0]         pp_cnt;
		logic                   pp_rdy;
		logic                   pp_done;
		logic                   pp_err;
		logic                   err_en;
		logic                   pto_en;
		logic                   emto_en;
		logic                   pp_ireq;
		logic                   dp_ireq;
		logic                   write_posting_en;
		logic                   f_acc;
		logic                   f_wr;
		logic                   f_rd;
		logic                   f_pto;
		logic                   f_emto;
		logic                   dp_sleep;
		logic                   idle_err;
		logic [1:0][AW-1:0]     fa;
		logic [1:0][DW-1:0]     fd;
		logic                   rp;
		logic [1:0]             cnt;
		logic                   dp_rdy;
		logic                   em_v;
		logic [AW-1:0]          em_a;
		logic [DW-1:0]          em_d;
		logic [ETW-1:0]         em_cnt;
		logic [3:0]             irq_st;
		logic [3:0]             irq_msk;
		logic                   irq;
		logic                   awh;
		logic                   wh;
		logic [31:0]            awa;
		logic [31:0]            wd;
		logic [3:0]             ws;
		logic                   awrdy;
		logic                   wrdy;
		logic                   bv;
		logic [1:0]             br;
		logic                   arrdy;
		logic                   rv;
		logic [31:0]            rd;
		logic [1:0]             rr;
	} ipbm_state_type;

	ipbm_state_type c_q;
	ipbm_state_type n_d;

	// Address falls in one of the covered peripheral windows
	function automatic logic in_rng(input logic [15:0] a);
		in_rng = (a >= `IPBM_R0_LO && a <= `IPBM_R0_HI) ||
			(a >= `IPBM_R1_LO && a <= `IPBM_R1_HI) ||
			(a >= `IPBM_R2_LO && a <= `IPBM_R2_HI);
	endfunction

	// Byte address to register index; misaligned or high addresses never match
	function automatic logic [11:0] reg_idx(input logic [31:0] a);
		reg_idx = {(a[31:13] != 19'h0_0000) || (a[1:0] != 2'h0), a[12:2]};
	endfunction

	logic        pp_take;
	logic        pp_bad;
	logic        push;
	logic        pop;
	logic        idle_go;
	logic [3:0]  ev;
	logic [11:0] ix;
	logic [15:0] rv16;
	logic        rok;

	// Read mux, registers, byte lanes and all port behaviour
	always_comb
	begin
		n_d = c_q;
		n_d.pp_done = 1'b0;
		n_d.pp_err = 1'b0;
		n_d.idle_err = 1'b0;
		ev = 4'h0;
		rv16 = 16'h0000;
		rok = 1'b1;
		ix = 12'h000;
		idle_go = idle_insn && !cpu_idle && !master_idle;

		// Write channel: address and data may arrive in either order
		if (awvalid && c_q.awrdy)
		begin
			n_d.awh = 1'b1;
			n_d.awa = awaddr;
		end
		if (wvalid && c_q.wrdy)
		begin
			n_d.wh = 1'b1;
			n_d.wd = wdata;
			n_d.ws = wstrb;
		end
		if (c_q.bv && bready)
			n_d.bv = 1'b0;
		if (n_d.awh && n_d.wh && !c_q.bv)
		begin
			ix = reg_idx(n_d.awa);
			n_d.bv = 1'b1;
			n_d.br = `IPBM_RESP_OKAY;
			n_d.awh = 1'b0;
			n_d.wh = 1'b0;
			// Status registers ignore writes: error flags are reset-only, interrupt status clears on read
			case (ix)
				{1'b0, `IPBM_IDX_PP_CFG}:
					if (n_d.ws[1])
						n_d.err_en = n_d.wd[`IPBM_B_ERR_EN];
				{1'b0, `IPBM_IDX_DP_CFG}:
					if (n_d.ws[0])
						n_d.write_posting_en = n_d.wd[`IPBM_B_WPE];
				{1'b0, `IPBM_IDX_TIMEOUT_CONTROL_REG}:
					if (n_d.ws[0])
					begin
						n_d.pto_en = n_d.wd[`IPBM_B_PTO_EN];
						n_d.emto_en = n_d.wd[`IPBM_B_EMTO_EN];
					end
				{1'b0, `IPBM_IDX_ICR}:
					if (n_d.ws[0])
					begin
						n_d.pp_ireq = n_d.wd[`IPBM_B_PP_IREQ];
						n_d.dp_ireq = n_d.wd[`IPBM_B_DP_IREQ];
					end
				{1'b0, `IPBM_IDX_IRQ_MSK}:
					if (n_d.ws[0])
						n_d.irq_msk = n_d.wd[3:0];
				{1'b0, `IPBM_IDX_PP_ERR},
				{1'b0, `IPBM_IDX_DP_ERR},
				{1'b0, `IPBM_IDX_IRQ_ST}:
					n_d.br = `IPBM_RESP_OKAY;
				default:
					n_d.br = `IPBM_RESP_SLVERR;
			endcase
		end

		// Read channel; status is sampled before this cycle's events
		if (c_q.rv && rready)
			n_d.rv = 1'b0;
		if (arvalid && c_q.arrdy)
		begin
			case (reg_idx(araddr))
				{1'b0, `IPBM_IDX_PP_CFG}:
					rv16[`IPBM_B_ERR_EN] = c_q.err_en;
				{1'b0, `IPBM_IDX_PP_ERR}:
				begin
					rv16[`IPBM_B_ACC_ERR] = c_q.f_acc;
					rv16[`IPBM_B_PTO] = c_q.f_pto;
					rv16[`IPBM_B_WR_ERR] = c_q.f_wr;
					rv16[`IPBM_B_RD_ERR] = c_q.f_rd;
				end
				{1'b0, `IPBM_IDX_DP_CFG}:
					rv16[`IPBM_B_WPE] = c_q.write_posting_en;
				{1'b0, `IPBM_IDX_DP_ERR}:
					rv16[`IPBM_B_EMTO] = c_q.f_emto;
				{1'b0, `IPBM_IDX_TIMEOUT_CONTROL_REG}:
				begin
					rv16[`IPBM_B_PTO_EN] = c_q.pto_en;
					rv16[`IPBM_B_EMTO_EN] = c_q.emto_en;
				end
				{1'b0, `IPBM_IDX_ICR}:
				begin
					rv16[`IPBM_B_PP_IREQ] = c_q.pp_ireq;
					rv16[`IPBM_B_DP_IREQ] = c_q.dp_ireq;
				end
				{1'b0, `IPBM_IDX_IRQ_ST}:
				begin
					rv16[3:0] = c_q.irq_st;
					n_d.irq_st = 4'h0;
				end
				{1'b0, `IPBM_IDX_IRQ_MSK}:
					rv16[3:0] = c_q.irq_msk;
				default:
					rok = 1'b0;
			endcase
			n_d.rv = 1'b1;
			n_d.rd = {16'h0000, rv16};
			n_d.rr = rok ? `IPBM_RESP_OKAY : `IPBM_RESP_SLVERR;
		end

		// Peripheral port sequencer
		pp_take = pp_req_valid && c_q.pp_rdy;
		pp_bad = pp_req_invalid && in_rng(pp_req_addr);
		case (c_q.pp_st)
			ipbm_pkg::PP_RDY:
				if (pp_take && pp_bad && c_q.err_en)
				begin
					// Answer at once with error; returned data must be discarded
					n_d.pp_done = 1'b1;
					n_d.pp_err = 1'b1;
					n_d.f_acc = 1'b1;
					n_d.f_wr = c_q.f_wr | pp_req_write;
					n_d.f_rd = c_q.f_rd | !pp_req_write;
					ev[`IPBM_I_ACC] = 1'b1;
				end
				else if (pp_take && pp_bad)
					n_d.pp_st = ipbm_pkg::PP_HANG;
				else if (pp_take)
				begin
					n_d.pp_st = ipbm_pkg::PP_WAIT;
					n_d.pp_cnt = '0;
				end
				else if (idle_insn && c_q.pp_ireq)
				begin
					n_d.pp_st = ipbm_pkg::PP_SLEEP;
					n_d.idle_err = idle_go;
				end
			ipbm_pkg::PP_WAIT:
				if (pp_resp)
				begin
					n_d.pp_st = ipbm_pkg::PP_RDY;
					n_d.pp_done = 1'b1;
				end
				else if (c_q.pto_en && c_q.pp_cnt == PP_LAST)
				begin
					n_d.pp_st = ipbm_pkg::PP_RDY;
					n_d.pp_done = 1'b1;
					n_d.pp_err = 1'b1;
					n_d.f_pto = 1'b1;
					ev[`IPBM_I_PTO] = 1'b1;
				end
				else if (c_q.pto_en)
					n_d.pp_cnt = c_q.pp_cnt + PTW'(1);
			ipbm_pkg::PP_HANG:
				n_d.pp_st = ipbm_pkg::PP_HANG;
			ipbm_pkg::PP_SLEEP:
				if (wake)
					n_d.pp_st = ipbm_pkg::PP_RDY;
			default:
				n_d.pp_st = ipbm_pkg::PP_RDY;
		endcase
		// Hung and sleeping port refuse everything; only reset leaves the hang
		n_d.pp_rdy = (n_d.pp_st == ipbm_pkg::PP_RDY);

		// Data port idle entry and wake
		if (c_q.dp_sleep && wake)
			n_d.dp_sleep = 1'b0;
		else if (!c_q.dp_sleep && idle_insn && c_q.dp_ireq)
		begin
			n_d.dp_sleep = 1'b1;
			n_d.idle_err = n_d.idle_err | idle_go;
		end
		ev[`IPBM_I_IDLE] = n_d.idle_err;

		// Posting entries: push at write slot, pop at head
		push = dp_wr_valid && c_q.dp_rdy;
		pop = c_q.em_v && em_wr_ready;
		if (push)
		begin
			n_d.fa[c_q.rp ^ c_q.cnt[0]] = dp_wr_addr;
			n_d.fd[c_q.rp ^ c_q.cnt[0]] = dp_wr_data;
		end
		if (pop)
			n_d.rp = !c_q.rp;
		n_d.cnt = 2'(c_q.cnt + {1'b0, push} - {1'b0, pop});
		n_d.em_v = (n_d.cnt != 2'h0);
		n_d.em_a = n_d.fa[n_d.rp];
		n_d.em_d = n_d.fd[n_d.rp];
		// Without posting one entry holds the write until the memory side takes it
		n_d.dp_rdy = !n_d.dp_sleep && (n_d.cnt < (n_d.write_posting_en ? 2'h2 : 2'h1));

		// External memory time-out on a stalled transfer
		if (pop || !c_q.em_v)
			n_d.em_cnt = '0;
		else if (c_q.em_cnt != EM_LAST)
			n_d.em_cnt = c_q.em_cnt + ETW'(1);
		else if (c_q.emto_en && !c_q.f_emto)
		begin
			n_d.f_emto = 1'b1;
			ev[`IPBM_I_EMTO] = 1'b1;
		end

		// Sticky interrupt status: a new event wins over the read clear
		n_d.irq_st = n_d.irq_st | ev;
		n_d.irq = |(n_d.irq_st & n_d.irq_msk);
		n_d.awrdy = !n_d.awh && !n_d.bv;
		n_d.wrdy = !n_d.wh && !n_d.bv;
		n_d.arrdy = !n_d.rv;
	end

	// State register; all ready outputs start high after reset
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			c_q <= '0;
			c_q.pp_st <= ipbm_pkg::PP_RDY;
			c_q.err_en <= `IPBM_RST_ERR_EN;
			c_q.pp_rdy <= 1'b1;
			c_q.dp_rdy <= 1'b1;
			c_q.awrdy <= 1'b1;
			c_q.wrdy <= 1'b1;
			c_q.arrdy <= 1'b1;
		end
		else
			c_q <= n_d;
	end

	// Outputs come straight from the state register
	assign awready      = c_q.awrdy;
	assign wready       = c_q.wrdy;
	assign bvalid       = c_q.bv;
	assign bresp        = c_q.br;
	assign arready      = c_q.arrdy;
	assign rvalid       = c_q.rv;
	assign rdata        = c_q.rd;
	assign rresp        = c_q.rr;
	assign pp_req_ready = c_q.pp_rdy;
	assign pp_done      = c_q.pp_done;
	assign pp_err       = c_q.pp_err;
	assign pp_idle      = (c_q.pp_st == ipbm_pkg::PP_SLEEP);
	assign dp_idle      = c_q.dp_sleep;
	assign idle_bus_err = c_q.idle_err;
	assign dp_wr_ready  = c_q.dp_rdy;
	assign em_wr_valid  = c_q.em_v;
	assign em_wr_addr   = c_q.em_a;
	assign em_wr_data   = c_q.em_d;
	assign irq          = c_q.irq;

	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	sequence s_take_bad;
		c_q.pp_st == ipbm_pkg::PP_RDY && pp_req_valid && c_q.pp_rdy && pp_req_invalid;
	endsequence
	sequence s_err_resp;
		pp_err && pp_done && c_q.f_acc;
	endsequence

	property p_rng_err;
		s_take_bad and in_rng(pp_req_addr) && c_q.err_en |=> s_err_resp;
	endproperty
	a_rng_err: assert property (p_rng_err) else $error("covered invalid access not flagged");

	property p_out_rng;
		s_take_bad and !in_rng(pp_req_addr) |=> !pp_err;
	endproperty
	a_out_rng: assert property (p_out_rng) else $error("error outside covered ranges");

	property p_hang;
		s_take_bad and in_rng(pp_req_addr) && !c_q.err_en |=> (!pp_req_ready && !pp_err)[*4];
	endproperty
	a_hang: assert property (p_hang) else $error("disabled error did not hang");

	property p_dir;
		s_take_bad and in_rng(pp_req_addr) && c_q.err_en |=>
			($past(pp_req_write) ? c_q.f_wr : c_q.f_rd);
	endproperty
	a_dir: assert property (p_dir) else $error("direction flag wrong");

	property p_timeout;
		c_q.pp_st == ipbm_pkg::PP_WAIT && c_q.pto_en && c_q.pp_cnt == PP_LAST && !pp_resp
			|=> c_q.f_pto && pp_err && pp_req_ready;
	endproperty
	a_timeout: assert property (p_timeout) else $error("time-out not flagged at limit");

	property p_to_off;
		c_q.pp_st == ipbm_pkg::PP_WAIT && !c_q.pto_en && !pp_resp
			|=> c_q.pp_st == ipbm_pkg::PP_WAIT && !pp_done;
	endproperty
	a_to_off: assert property (p_to_off) else $error("time-out without enable");

	property p_sleep;
		pp_idle |-> !pp_req_ready && !pp_done;
	endproperty
	a_sleep: assert property (p_sleep) else $error("idle port accepted request");

	property p_idle_err;
		c_q.pp_st == ipbm_pkg::PP_RDY && !(pp_req_valid && pp_req_ready) && idle_insn
			&& c_q.pp_ireq && !cpu_idle && !master_idle |=> idle_bus_err && pp_idle;
	endproperty
	a_idle_err: assert property (p_idle_err) else $error("idle bus error missing");

	property p_post;
		dp_wr_ready |-> !dp_idle && c_q.cnt < (c_q.write_posting_en ? 2'h2 : 2'h1);
	endproperty
	a_post: assert property (p_post) else $error("posting capacity exceeded");

	property p_sticky;
		c_q.f_acc || c_q.f_wr || c_q.f_rd || c_q.f_pto || c_q.f_emto |=>
			({c_q.f_acc, c_q.f_wr, c_q.f_rd, c_q.f_pto, c_q.f_emto} &
			$past({c_q.f_acc, c_q.f_wr, c_q.f_rd, c_q.f_pto, c_q.f_emto})) ==
			$past({c_q.f_acc, c_q.f_wr, c_q.f_rd, c_q.f_pto, c_q.f_emto});
	endproperty
	a_sticky: assert property (p_sticky) else $error("error flag cleared");

	property p_irq;
		irq == |(c_q.irq_st & c_q.irq_msk);
	endproperty
	a_irq: assert property (p_irq) else $error("interrupt level wrong");
endmodule
`default_nettype wire

// File: src/ipbm_map.svh
// Register indices, field positions, reset values and counts of the port monitor
`ifndef IPBM_MAP_SVH
`define IPBM_MAP_SVH
// Register indices; byte address is four times the index
`define IPBM_IDX_PP_CFG   11'h100
`define IPBM_IDX_PP_ERR   11'h102
`define IPBM_IDX_DP_CFG   11'h200
`define IPBM_IDX_DP_ERR   11'h202
`define IPBM_IDX_TIMEOUT_CONTROL_REG     11'h400
`define IPBM_IDX_ICR      11'h401
`define IPBM_IDX_IRQ_ST   11'h402
`define IPBM_IDX_IRQ_MSK  11'h403
// Field positions
`define IPBM_B_ERR_EN     15
`define IPBM_B_ACC_ERR    15
`define IPBM_B_PTO        12
`define IPBM_B_WR_ERR     4
`define IPBM_B_RD_ERR     3
`define IPBM_B_WPE        7
`define IPBM_B_EMTO       12
`define IPBM_B_PTO_EN     0
`define IPBM_B_EMTO_EN    1
`define IPBM_B_PP_IREQ    0
`define IPBM_B_DP_IREQ    1
// Interrupt status bits
`define IPBM_I_ACC        0
`define IPBM_I_PTO        1
`define IPBM_I_IDLE       2
`define IPBM_I_EMTO       3
// Covered peripheral address ranges
`define IPBM_R0_LO        16'h0000
`define IPBM_R0_HI        16'h03FF
`define IPBM_R1_LO        16'h1400
`define IPBM_R1_HI        16'h17FF
`define IPBM_R2_LO        16'h2000
`define IPBM_R2_HI        16'h23FF
// Reset values and counts
`define IPBM_RST_ERR_EN   1'b1
`define IPBM_PP_TO_CYC    512
`define IPBM_EM_TO_CYC    1024
`define IPBM_RESP_OKAY    2'h0
`define IPBM_RESP_SLVERR  2'h2
`endif

// File: src/ipbm_pkg.sv
// Types shared by the port monitor
`default_nettype none
package ipbm_pkg;
	typedef enum logic [1:0] {
		PP_RDY   = 2'b00,
		PP_WAIT  = 2'b01,
		PP_HANG  = 2'b10,
		PP_SLEEP = 2'b11
	} ipbm_pp_state_type;
endpackage
`default_nettype wire

// File: sim/ipbm_far.sv
// Peripheral and external memory stand-in for the port monitor bench
`timescale 1ns/1ps
`default_nettype none
module ipbm_far (
	input  wire logic       aclk,
	input  wire logic       aresetn,
	input  wire logic       pp_req_valid,
	input  wire logic       pp_req_ready,
	input  wire logic [7:0] dly,
	output logic            pp_resp,
	input  wire logic       stall,
	output logic            em_wr_ready
);
	logic [7:0] cnt_q;

	// Answer each taken access after dly cycles; zero models a peripheral that never answers
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			cnt_q <= 8'h00;
		else if (pp_req_valid && pp_req_ready)
			cnt_q <= dly;
		else if (cnt_q != 8'h00)
			cnt_q <= cnt_q - 8'h01;
	end

	// One-cycle answer pulse, so a late answer cannot be mistaken for a second one
	assign pp_resp = (cnt_q == 8'h01);
	// Memory side stalls on command to fill the posting entries
	assign em_wr_ready = !stall;
endmodule
`default_nettype wire

// File: sim/internal_port_bus_error_monitor_bench.sv
// Self-checking bench for the port monitor
`timescale 1ns/1ps
`default_nettype none
`include "ipbm_map.svh"
`define CHK(n, e, v) begin comparisons++; if ((v) !== (e)) begin num_errors++; $display("[ERR] %s exp %0h got %0h", n, e, v); end end
module internal_port_bus_error_monitor_bench;
	localparam int TO = 8;
	logic        aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
	logic [31:0] awaddr = '0, wdata = '0, araddr = '0, rdata, em_wr_data, dp_wr_data = '0;
	logic [3:0]  wstrb = 4'hF;
	logic [1:0]  bresp, rresp;
	logic        awready, wready, bvalid, arready, rvalid, pp_resp, pp_req_ready, pp_done, pp_err;
	logic        pp_req_valid = 0, pp_req_write = 0, pp_req_invalid = 0, stall = 0;
	logic [15:0] pp_req_addr = '0;
	logic        idle_insn = 0, cpu_idle = 0, master_idle = 0, wake = 0, pp_idle, dp_idle, idle_bus_err;
	logic        dp_wr_valid = 0, dp_wr_ready, em_wr_valid, em_wr_ready, irq;
	logic [23:0] dp_wr_addr = '0, em_wr_addr;
	logic [7:0]  dly = 8'h00;
	int          num_errors = 0, comparisons = 0;
	logic [1:0]  wr_resp;

	ipbm_top #(.PP_TO_CYC(TO), .EM_TO_CYC(TO)) dut (.aclk, .aresetn, .awvalid, .awready, .awaddr, .wvalid,
		.wready, .wdata, .wstrb, .bvalid, .bready, .bresp, .arvalid, .arready, .araddr, .rvalid, .rready, .rdata,
		.rresp, .pp_req_valid, .pp_req_ready, .pp_req_addr, .pp_req_write, .pp_req_invalid, .pp_resp, .pp_done,
		.pp_err, .idle_insn, .cpu_idle, .master_idle, .wake, .pp_idle, .dp_idle, .idle_bus_err, .dp_wr_valid,
		.dp_wr_ready, .dp_wr_addr, .dp_wr_data, .em_wr_valid, .em_wr_ready, .em_wr_addr, .em_wr_data, .irq);
	ipbm_far far (.aclk, .aresetn, .pp_req_valid, .pp_req_ready, .dly, .pp_resp, .stall, .em_wr_ready);

	// Free-running 250 MHz clock
	always #2 aclk = ~aclk;

	task automatic finish_test;
		if (num_errors == 0 && comparisons > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	// Register write; address and data offered together, each dropped once taken
	task automatic axw(input logic [15:0] a, input logic [15:0] d);
		logic ta;
		logic tw;
		logic tb;
		awaddr <= {16'h0000, a};
		wdata <= {16'h0000, d};
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		// Bready stays high between writes, so back-to-back calls never toggle it in one step
		do
		begin
			@(negedge aclk);
			ta = awready && awvalid;
			tw = wready && wvalid;
			tb = bvalid && bready;
			if (tb)
				wr_resp = bresp;
			@(posedge aclk);
			if (ta)
				awvalid <= 1'b0;
			if (tw)
				wvalid <= 1'b0;
		end
		while (!tb);
	endtask

	task automatic axr(input logic [15:0] a, output logic [31:0] d, output logic [1:0] r);
		araddr <= {16'h0000, a};
		arvalid <= 1'b1;
		rready <= 1'b1;
		do
			@(negedge aclk);
		while (!arready);
		@(posedge aclk);
		arvalid <= 1'b0;
		do
			@(negedge aclk);
		while (!rvalid);
		d = rdata;
		r = rresp;
		@(posedge aclk);
	endtask

	task automatic rd(input logic [15:0] a, input logic [15:0] e);
		logic [31:0] d;
		logic [1:0]  r;
		axr(a, d, r);
		`CHK("rdata", {16'h0000, e}, d)
	endtask

	// One peripheral access; n counts cycles from the take to the done pulse
	task automatic pp(input logic [15:0] a, input logic w, input logic inv, output logic e, output int n);
		pp_req_addr <= a;
		pp_req_write <= w;
		pp_req_invalid <= inv;
		pp_req_valid <= 1'b1;
		do
			@(negedge aclk);
		while (!pp_req_ready);
		@(posedge aclk);
		pp_req_valid <= 1'b0;
		n = 0;
		do
		begin
			@(negedge aclk);
			n++;
		end
		while (!pp_done && n < 200);
		e = pp_err;
		@(posedge aclk);
	endtask

	task automatic t_reset;
		logic [31:0] d;
		logic [1:0]  r;
		rd(16'h0400, 16'h8000);
		rd(16'h0408, 16'h0000);
		rd(16'h0808, 16'h0000);
		axr(16'h3000, d, r);
		`CHK("rresp", `IPBM_RESP_SLVERR, r)
	endtask

	// Edges of each covered range, then the addresses just outside them
	task automatic t_ranges;
		logic [15:0] ad [11] = '{16'h0000, 16'h03FF, 16'h1400, 16'h17FF, 16'h2000, 16'h23FF,
			16'h0400, 16'h13FF, 16'h1800, 16'h1FFF, 16'h2400};
		logic        e;
		int          n;
		for (int i = 0; i < 11; i++)
		begin
			dly <= (i < 6) ? 8'h00 : 8'h03;
			pp(ad[i], i[0], 1'b1, e, n);
			`CHK("pp_err", i < 6, e)
			`CHK("pp_cyc", (i < 6) ? 1 : 4, n)
		end
		rd(16'h0408, 16'h8018);
	endtask

	task automatic t_irq;
		axw(16'h100C, 16'h000F);
		@(negedge aclk);
		`CHK("irq", 1'b1, irq)
		@(posedge aclk);
		rd(16'h1008, 16'h0001);
		repeat (2) @(posedge aclk);
		@(negedge aclk);
		`CHK("irq", 1'b0, irq)
		@(posedge aclk);
		rd(16'h1008, 16'h0000);
		axw(16'h0408, 16'h0000);
		`CHK("bresp", `IPBM_RESP_OKAY, wr_resp)
		rd(16'h0408, 16'h8018);
	endtask

	// Slow peripheral answered late with the time-out off; one that never answers is cut short with it on
	task automatic t_timeout;
		logic e;
		int   n;
		dly <= 8'(TO + 6);
		pp(16'h0500, 1'b0, 1'b0, e, n);
		`CHK("pp_err", 1'b0, e)
		`CHK("pp_cyc", TO + 7, n)
		axw(16'h1000, 16'h0003);
		dly <= 8'h00;
		pp(16'h0500, 1'b0, 1'b0, e, n);
		`CHK("pp_err", 1'b1, e)
		`CHK("to_cyc", TO + 1, n)
		rd(16'h0408, 16'h9018);
	endtask

	// Memory side stalls while writes are offered; then entries drain in order
	task automatic t_fill(input logic [23:0] b, input int exp);
		logic t;
		int   k;
		k = 0;
		stall <= 1'b1;
		dp_wr_addr <= b;
		dp_wr_data <= {8'h00, b};
		dp_wr_valid <= 1'b1;
		repeat (12)
		begin
			@(negedge aclk);
			t = dp_wr_ready && dp_wr_valid;
			@(posedge aclk);
			if (t)
			begin
				k++;
				dp_wr_addr <= 24'(b + k);
				dp_wr_data <= {8'h00, 24'(b + k)};
			end
		end
		dp_wr_valid <= 1'b0;
		stall <= 1'b0;
		`CHK("accepted", exp, k)
		for (int j = 0; j < k; j++)
		begin
			do
				@(negedge aclk);
			while (!em_wr_valid);
			`CHK("em_addr", 24'(b + j), em_wr_addr)
			`CHK("em_data", {8'h00, 24'(b + j)}, em_wr_data)
			@(posedge aclk);
		end
	endtask

	task automatic t_idle(input logic ci, input logic mi, input logic eb);
		cpu_idle <= ci;
		master_idle <= mi;
		idle_insn <= 1'b1;
		@(posedge aclk);
		idle_insn <= 1'b0;
		@(negedge aclk);
		`CHK("pp_idle", 1'b1, pp_idle)
		`CHK("dp_idle", 1'b1, dp_idle)
		`CHK("idle_err", eb, idle_bus_err)
		`CHK("pp_rdy", 1'b0, pp_req_ready)
		`CHK("dp_rdy", 1'b0, dp_wr_ready)
		// No requests are offered until both ports are woken
		@(posedge aclk);
		wake <= 1'b1;
		@(posedge aclk);
		wake <= 1'b0;
		cpu_idle <= 1'b0;
		master_idle <= 1'b0;
		repeat (3) @(posedge aclk);
	endtask

	// Error reporting off: a covered invalid access hangs the port until reset
	task automatic t_hang;
		axw(16'h0400, 16'h0000);
		pp_req_addr <= 16'h0010;
		pp_req_invalid <= 1'b1;
		pp_req_valid <= 1'b1;
		do
			@(negedge aclk);
		while (!pp_req_ready);
		@(posedge aclk);
		pp_req_valid <= 1'b0;
		repeat (20) @(posedge aclk);
		@(negedge aclk);
		`CHK("pp_rdy", 1'b0, pp_req_ready)
		`CHK("pp_done", 1'b0, pp_done)
		@(posedge aclk);
		aresetn <= 1'b0;
		repeat (6) @(posedge aclk);
		aresetn <= 1'b1;
		rd(16'h0400, 16'h8000);
		rd(16'h0408, 16'h0000);
	endtask

	// Watchdog well beyond the expected run length
	initial
	begin
		repeat (20000) @(posedge aclk);
		num_errors++;
		finish_test;
	end

	initial
	begin
		repeat (6) @(posedge aclk);
		aresetn <= 1'b1;
		t_reset;
		t_ranges;
		t_irq;
		t_timeout;
		t_fill(24'h00_0100, 1);
		axw(16'h0800, 16'h0080); // posting changed only with the memory side idle
		t_fill(24'h00_0200, 2);
		rd(16'h0808, 16'h1000);
		axw(16'h1004, 16'h0003);
		t_idle(1'b0, 1'b0, 1'b1);
		t_idle(1'b1, 1'b0, 1'b0);
		t_idle(1'b0, 1'b1, 1'b0);
		t_hang;
		finish_test;
	end
endmodule
`default_nettype wire
